// [inc/wwdg_pkg.sv]
// Package of the window watchdog: timing constants, strap and fault types
// Assumes a 40 MHz core clock; all counts derive from it
package wwdg_pkg;
   // Core clock rate
   localparam longint unsigned CLK_HZ = 64'd40000000;
   // Window timeouts in microseconds
   localparam longint unsigned WIN_SHORT_US = 64'd250000;
   localparam longint unsigned WIN_LONG_US = 64'd2500000;
   localparam longint unsigned WIN_SHORT_CYC = (WIN_SHORT_US * CLK_HZ) / 64'd1000000;
   localparam longint unsigned WIN_LONG_CYC = (WIN_LONG_US * CLK_HZ) / 64'd1000000;
   // Default capacitor window: 6.25 ms base for no capacitor
   localparam longint unsigned WIN_CAP_US = 64'd6250;
   localparam longint unsigned WIN_CAP_CYC = (WIN_CAP_US * CLK_HZ) / 64'd1000000;
   // Ratio divisors in tenths, so integer division keeps one decimal
   localparam longint unsigned DIV_HI_SHORT_X10 = 64'd1249;
   localparam longint unsigned DIV_HI_LONG_X10 = 64'd1277;
   localparam longint unsigned DIV_LO_SHORT_X10 = 64'd318;
   localparam longint unsigned DIV_LO_LONG_X10 = 64'd320;
   localparam longint unsigned DIV_HI_CAP_X10 = 64'd645;
   localparam longint unsigned DIV_LO_CAP_X10 = 64'd258;
   // Worst-case capacitor divisors, kept for reference of bounds
   localparam longint unsigned DIV_HI_CAP_MAX_X10 = 64'd516;
   localparam longint unsigned DIV_HI_CAP_MIN_X10 = 64'd927;
   localparam longint unsigned DIV_LO_CAP_MAX_X10 = 64'd235;
   localparam longint unsigned DIV_LO_CAP_MIN_X10 = 64'd287;
   // Fault reset hold time in microseconds
   localparam longint unsigned RST_HOLD_US = 64'd25000;
   localparam longint unsigned RST_HOLD_CYC = (RST_HOLD_US * CLK_HZ) / 64'd1000000;
   // Counter width
   localparam int CNT_W = 27;
   // Reset values
   localparam logic [CNT_W-1:0] CNT_RST = 27'h0;

   // Strap settings
   typedef struct packed {
      logic cap_mode;
      logic timeout_select;
      logic window_ratio_select;
   } wwdg_straps_t;

   // Fault flags
   typedef struct packed {
      logic early;
      logic late;
   } wwdg_fault_t;

   // Watchdog states
   typedef enum logic [2:0] {
      WWDG_FIRST = 3'b001,
      WWDG_ARMED = 3'b010,
      WWDG_HOLD = 3'b100
   } wwdg_state_e_t;
endpackage : wwdg_pkg

// [src/wwdg_sync.sv]
// Two-stage synchroniser for the trigger pin
// Assumes an asynchronous source; output lags the pin by two edges
`timescale 1ns/1ps
module wwdg_sync
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic s1;
      logic s2;
   } wwdg_sync_st_t;

   wwdg_sync_st_t st;
   wwdg_sync_st_t next_st;

   ////////////////////////////////////////////////////////////////////
   // Shift chain; first stage read only by the second
   always_comb
   begin
      next_st.s1 = din;
      next_st.s2 = st.s1;
   end

   // Register stage
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= 2'h0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign dout = st.s2;
endmodule : wwdg_sync

// [src/wwdg_top.sv]
// Window watchdog core: window timing, fault detection and reset output
// Assumes mclk is free running; straps are static after reset release
//
// Function
// - Free-running clock; trigger rising edge acts on the third internal clock edge after it (two-stage sync, then state register).
// - Ratio strap chooses one of two fixed lower-boundary ratios.
// - Ratio high: boundary is window over 124.9 (short) or 127.7 (long).
// - Ratio low: boundary is window over 31.8 (short) or 32 (long).
// - Capacitor mode, ratio high: boundary is window over 64.5.
// - Capacitor mode, ratio low: boundary is window over 25.8.
// - Window is 0.25 s, 2.5 s, or capacitor programmed.
// - Timeout strap high selects the 2.5 s window when capacitor mode is off.
// - Missing trigger or early trigger is a fault causing reset.
// - Each trigger edge outside the reset hold clears timers; unless early, it starts a new window.
// - Lower-boundary check off in first window, on after first edge.
`timescale 1ns/1ps
module wwdg_top
#(
   parameter logic [wwdg_pkg::CNT_W-1:0] WIN_SHORT = wwdg_pkg::CNT_W'(wwdg_pkg::WIN_SHORT_CYC),
   parameter logic [wwdg_pkg::CNT_W-1:0] WIN_LONG = wwdg_pkg::CNT_W'(wwdg_pkg::WIN_LONG_CYC),
   parameter logic [wwdg_pkg::CNT_W-1:0] WIN_CAP = wwdg_pkg::CNT_W'(wwdg_pkg::WIN_CAP_CYC),
   parameter logic [wwdg_pkg::CNT_W-1:0] RST_HOLD = wwdg_pkg::CNT_W'(wwdg_pkg::RST_HOLD_CYC)
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic watchdog_trigger_in,
   input wire wwdg_pkg::wwdg_straps_t straps,
   output logic wd_reset_n,
   output wwdg_pkg::wwdg_fault_t fault
);
   import wwdg_pkg::*;

   // Lower boundaries per strap setting, divisors in tenths
   localparam logic [CNT_W-1:0] LB_HI_SHORT = CNT_W'((64'(WIN_SHORT) * 64'd10) / DIV_HI_SHORT_X10);
   localparam logic [CNT_W-1:0] LB_HI_LONG = CNT_W'((64'(WIN_LONG) * 64'd10) / DIV_HI_LONG_X10);
   localparam logic [CNT_W-1:0] LB_LO_SHORT = CNT_W'((64'(WIN_SHORT) * 64'd10) / DIV_LO_SHORT_X10);
   localparam logic [CNT_W-1:0] LB_LO_LONG = CNT_W'((64'(WIN_LONG) * 64'd10) / DIV_LO_LONG_X10);
   localparam logic [CNT_W-1:0] LB_HI_CAP = CNT_W'((64'(WIN_CAP) * 64'd10) / DIV_HI_CAP_X10);
   localparam logic [CNT_W-1:0] LB_LO_CAP = CNT_W'((64'(WIN_CAP) * 64'd10) / DIV_LO_CAP_X10);

   typedef struct packed {
      wwdg_state_e_t state;
      logic [CNT_W-1:0] cnt;
      logic trig_q;
      logic [2:0] cfg_meta;
      logic [2:0] cfg;
      logic rst_out_n;
      wwdg_fault_t fault;
   } wwdg_top_st_t;

   wwdg_top_st_t st;
   wwdg_top_st_t next_st;
   logic trig_sync;
   logic trig_rise;
   logic [CNT_W-1:0] win_len;
   logic [CNT_W-1:0] low_bound;

   ////////////////////////////////////////////////////////////////////
   // Trigger pin synchroniser
   wwdg_sync u_sync
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .din(watchdog_trigger_in),
      .dout(trig_sync)
   );

   // Edge detect on synchronised trigger
   assign trig_rise = trig_sync & ~st.trig_q;

   ////////////////////////////////////////////////////////////////////
   // Window and boundary selection from registered straps
   always_comb
   begin
      win_len = WIN_SHORT;
      low_bound = LB_LO_SHORT;
      if (st.cfg[2])
      begin
         win_len = WIN_CAP;
         low_bound = st.cfg[0] ? LB_HI_CAP : LB_LO_CAP;
      end
      else if (st.cfg[1])
      begin
         win_len = WIN_LONG;
         low_bound = st.cfg[0] ? LB_HI_LONG : LB_LO_LONG;
      end
      else
      begin
         win_len = WIN_SHORT;
         low_bound = st.cfg[0] ? LB_HI_SHORT : LB_LO_SHORT;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      next_st = st;
      next_st.trig_q = trig_sync;
      // Strap pins pass two flip-flops before the window logic reads them
      next_st.cfg_meta = straps;
      next_st.cfg = st.cfg_meta;
      next_st.fault = 2'h0;
      case (st.state)
         WWDG_FIRST:
         begin
            next_st.rst_out_n = 1'b1;
            if (trig_rise)
            begin
               next_st.cnt = CNT_RST;
               next_st.state = WWDG_ARMED;
            end
            else if (st.cnt >= win_len - 1'b1)
            begin
               next_st.fault.late = 1'b1;
               next_st.cnt = CNT_RST;
               next_st.rst_out_n = 1'b0;
               next_st.state = WWDG_HOLD;
            end
            else
            begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
         WWDG_ARMED:
         begin
            next_st.rst_out_n = 1'b1;
            if (trig_rise && (st.cnt < low_bound))
            begin
               next_st.fault.early = 1'b1;
               next_st.cnt = CNT_RST;
               next_st.rst_out_n = 1'b0;
               next_st.state = WWDG_HOLD;
            end
            else if (trig_rise)
            begin
               next_st.cnt = CNT_RST;
            end
            else if (st.cnt >= win_len - 1'b1)
            begin
               next_st.fault.late = 1'b1;
               next_st.cnt = CNT_RST;
               next_st.rst_out_n = 1'b0;
               next_st.state = WWDG_HOLD;
            end
            else
            begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
         WWDG_HOLD:
         begin
            next_st.rst_out_n = 1'b0;
            if (st.cnt >= RST_HOLD - 1'b1)
            begin
               next_st.cnt = CNT_RST;
               next_st.rst_out_n = 1'b1;
               next_st.state = WWDG_FIRST;
            end
            else
            begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
         default:
         begin
            next_st.state = WWDG_FIRST;
            next_st.cnt = CNT_RST;
            next_st.rst_out_n = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st.state <= WWDG_FIRST;
         st.cnt <= CNT_RST;
         st.trig_q <= 1'b0;
         st.cfg_meta <= 3'h0;
         st.cfg <= 3'h0;
         st.rst_out_n <= 1'b1;
         st.fault <= 2'h0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign wd_reset_n = st.rst_out_n;
   assign fault = st.fault;
endmodule : wwdg_top

// [sim/wwdg_chk.sv]
// Assertion checker for the window watchdog core
// Assumes a bind onto wwdg_top that passes on its hold parameter
`timescale 1ns/1ps
module wwdg_chk
#(
   parameter logic [wwdg_pkg::CNT_W-1:0] RST_HOLD = wwdg_pkg::CNT_W'(wwdg_pkg::RST_HOLD_CYC)
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic watchdog_trigger_in,
   input wire wwdg_pkg::wwdg_straps_t straps,
   input wire logic wd_reset_n,
   input wire wwdg_pkg::wwdg_fault_t fault
);
   import wwdg_pkg::*;
   logic [CNT_W-1:0] low_cnt;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   //////////////////////////////////////////////////////////////////////
   // Counts cycles with the reset output low
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         low_cnt <= '0;
      else
         low_cnt <= wd_reset_n ? '0 : low_cnt + 1'b1;
   end
   sequence s_enter_hold;
      $fell(wd_reset_n) && fault != 2'b00;
   endsequence
   sequence s_pin_rose;
      $past(watchdog_trigger_in, 3) && !$past(watchdog_trigger_in, 4);
   endsequence
   property p_early_rst; fault.early |-> !wd_reset_n; endproperty
   property p_late_rst; fault.late |-> !wd_reset_n; endproperty
   property p_fell_cause; $fell(wd_reset_n) |-> s_enter_hold; endproperty
   property p_pulse; fault != 2'b00 |=> fault == 2'b00; endproperty
   property p_hold_len; $rose(wd_reset_n) |-> low_cnt == RST_HOLD; endproperty
   property p_hold_min; s_enter_hold |=> (!wd_reset_n) [*8]; endproperty
   property p_early_cause; fault.early |-> s_pin_rose; endproperty
   property p_quiet_hold; !wd_reset_n && !$fell(wd_reset_n) |-> fault == 2'b00; endproperty
   a_early_rst: assert property (p_early_rst) else $error("early fault without reset");
   a_late_rst: assert property (p_late_rst) else $error("late fault without reset");
   a_fell_cause: assert property (p_fell_cause) else $error("reset without fault");
   a_pulse: assert property (p_pulse) else $error("fault flag too long");
   a_hold_len: assert property (p_hold_len) else $error("reset hold length wrong");
   a_hold_min: assert property (p_hold_min) else $error("reset hold too short");
   a_early_cause: assert property (p_early_cause) else $error("early fault not after pin rise");
   a_quiet_hold: assert property (p_quiet_hold) else $error("fault during hold");
endmodule : wwdg_chk

// [sim/wwdg_cpu.sv]
// Model of the supervised processor driving the trigger pin
// Assumes fire is set by the bench with non-blocking assignment
`timescale 1ns/1ps
module wwdg_cpu
(
   input wire logic mclk,
   input wire logic fire,
   output logic watchdog_trigger_in
);
   logic [1:0] hi_cnt = 2'h0;
   // Software sets the pin, clears it three cycles later
   always @(negedge mclk)
   begin
      if (fire)
         hi_cnt <= 2'h3;
      else if (hi_cnt != 2'h0)
         hi_cnt <= hi_cnt - 2'h1;
   end
   assign watchdog_trigger_in = (hi_cnt != 2'h0);
endmodule : wwdg_cpu

// [sim/tb.sv]
// Self-checking bench of the window watchdog core
// Assumes shortened window and hold counts set below
`timescale 1ns/1ps
module tb;
   import wwdg_pkg::*;
   logic mclk, rst_n, fire, watchdog_trigger_in, wd_reset_n, low;
   wwdg_straps_t straps;
   wwdg_fault_t fault;
   int n_fail = 0, cmp_count = 0, n;
   wwdg_top #(.WIN_SHORT(27'h7d0), .WIN_LONG(27'hfa0), .WIN_CAP(27'h3e8), .RST_HOLD(27'h32)) i_wwdg_top
      (.mclk(mclk), .rst_n(rst_n), .watchdog_trigger_in(watchdog_trigger_in), .straps(straps),
       .wd_reset_n(wd_reset_n), .fault(fault));
   wwdg_cpu i_wwdg_cpu (.mclk(mclk), .fire(fire), .watchdog_trigger_in(watchdog_trigger_in));
   //////////////////////////////////////////////////////////////////////
   // Clock at 40 MHz
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t mismatch seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task finish_test;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   task do_reset(input wwdg_straps_t s);
      rst_n <= 1'b0;
      straps <= s;
      repeat (12) @(negedge mclk);
      rst_n <= 1'b1;
   endtask : do_reset
   task wait_low(input int lim);
      n = 0;
      while (wd_reset_n !== 1'b0 && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
   endtask : wait_low
   task idle(input int c);
      low = 1'b0;
      repeat (c)
      begin
         @(negedge mclk);
         if (wd_reset_n !== 1'b1)
            low = 1'b1;
      end
   endtask : idle
   task pulse;
      fire <= 1'b1;
      @(negedge mclk);
      fire <= 1'b0;
   endtask : pulse
   task recover;
      n = 0;
      while (wd_reset_n !== 1'b1 && n < 200)
      begin
         @(negedge mclk);
         n++;
      end
      check(wd_reset_n, 1'b1);
   endtask : recover
   // Missing trigger: reset near the end of the window
   task t_late(input wwdg_straps_t s, input int win);
      do_reset(s);
      wait_low(win + 50);
      check(n, win);
      check(fault, 2'h1);
      recover();
      // Early trigger after the hold must not fault: timing restarts unarmed
      pulse();
      idle(20);
      check(low, 1'b0);
      $display("late test %0d done", s);
   endtask : t_late
   // Trigger just after, then just before, the lower boundary
   task t_win(input wwdg_straps_t s, input int lb);
      do_reset(s);
      idle(10);
      pulse();
      idle(lb + 6);
      check(low, 1'b0);
      pulse();
      idle(lb - 7);
      check(low, 1'b0);
      pulse();
      wait_low(10);
      check(n < 10, 1'b1);
      check(fault, 2'h2);
      pulse();
      recover();
      $display("window test %0d done", s);
   endtask : t_win
   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      fire = 1'b0;
      straps = 3'h0;
      t_late(3'h0, 2000);
      t_late(3'h2, 4000);
      t_late(3'h4, 1000);
      t_win(3'h0, 62);
      t_win(3'h1, 16);
      t_win(3'h2, 125);
      t_win(3'h3, 31);
      t_win(3'h4, 38);
      t_win(3'h5, 15);
      finish_test();
   end
   // Watchdog against a hang
   initial
   begin
      repeat (40000) @(posedge mclk);
      n_fail++;
      finish_test();
   end
endmodule : tb
bind wwdg_top wwdg_chk #(.RST_HOLD(RST_HOLD)) i_wwdg_chk (.mclk(mclk), .rst_n(rst_n),
   .watchdog_trigger_in(watchdog_trigger_in), .straps(straps), .wd_reset_n(wd_reset_n), .fault(fault));
